//--- src/dcms_top.sv
// DMA channel mode sequencer: descriptors, arbitration, transfer engine.
// Assumes one memory slave that acks each request once; requests synchronous.
`timescale 1ns/1ps
module dcms_top
   import dcms_pkg::*;
#(
   parameter int NCH = DCMS_NCH
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [DCMS_AW-1:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [DCMS_AW-1:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   input wire logic [NCH-1:0] chan_req,
   output logic mem_req,
   output logic mem_we,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_wdata,
   output logic [1:0] mem_size,
   input wire logic [31:0] mem_rdata,
   input wire logic mem_ack,
   output logic irq
);
   localparam int CHW = $clog2(NCH);
   // --------------------------------------------------
   // Reset release
   // --------------------------------------------------
   logic rs1_reg;
   logic rst_n;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rs1_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rs1_reg <= 1'b1;
         rst_n <= rs1_reg;
      end
   end
   // --------------------------------------------------
   // State
   // --------------------------------------------------
   dcms_state_t state_reg, state_next;
   logic [CHW-1:0] ch_reg, ch_next;
   logic [1:0] widx_reg, widx_next;
   logic [7:0] beats_reg, beats_next;
   logic [31:0] buf_reg, buf_next, tbase_reg, tbase_next;
   logic [31:0] ctl_reg [NCH], ctl_next [NCH], sa_reg [NCH], sa_next [NCH];
   logic [31:0] da_reg [NCH], da_next [NCH], nxt_reg [NCH], nxt_next [NCH];
   logic [31:0] eaddr_reg [NCH], eaddr_next [NCH];
   logic [NCH-1:0] inten_reg, inten_next, done_reg, done_next, pend_reg, pend_next;
   logic [NCH-1:0] run_reg, run_next, intab_reg, intab_next;
   logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
   logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [NCH-1:0] elig;
   logic [CHW-1:0] gnt;
   logic gnt_any;
   logic [31:0] cctl, fbase;
   logic wr_en, rd_en, item_done;
   function automatic logic [31:0] inc_of(input logic [1:0] c);
      inc_of = (c == DCMS_INC_NONE) ? 32'h0 : (32'h1 << c);
   endfunction
   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            o[8*b+:8] = n[8*b+:8];
         end
      end
      merge = o;
   endfunction
   assign elig = pend_reg | run_reg;
   assign cctl = ctl_reg[ch_reg];
   assign fbase = {tbase_reg[31:16], nxt_reg[ch_reg][15:2], 2'b00};
   assign wr_en = s_awvalid & s_wvalid & ~bvalid_reg;
   assign rd_en = s_arvalid & ~rvalid_reg;
   assign item_done = (state_reg == DCMS_ST_WRITE) & mem_ack;
   dcms_arb #(.NCH(NCH), .CHW(CHW)) u_arb (
      .elig(elig),
      .gnt(gnt),
      .any(gnt_any)
   );
   // --------------------------------------------------
   // Bus, descriptors and engine next values
   // --------------------------------------------------
   always_comb begin
      logic [CHW-1:0] bch;
      logic [CHW-1:0] rch;
      logic [1:0] gmode;
      logic [7:0] bsz;
      logic [DCMS_CNT_W-1:0] cnt;
      bch = s_awaddr[4+:CHW];
      rch = s_araddr[4+:CHW];
      gmode = ctl_reg[gnt][DCMS_MODE_LSB+:2];
      bsz = DCMS_BURST_MAX >> ctl_reg[gnt][DCMS_BURST_LSB+:3];
      cnt = cctl[DCMS_CNT_LSB+:DCMS_CNT_W];
      state_next = state_reg;
      ch_next = ch_reg;
      widx_next = widx_reg;
      beats_next = beats_reg;
      buf_next = buf_reg;
      tbase_next = tbase_reg;
      ctl_next = ctl_reg;
      sa_next = sa_reg;
      da_next = da_reg;
      nxt_next = nxt_reg;
      eaddr_next = eaddr_reg;
      inten_next = inten_reg;
      done_next = done_reg;
      pend_next = pend_reg;
      run_next = run_reg;
      intab_next = intab_reg;
      bvalid_next = bvalid_reg & ~s_bready;
      bresp_next = bresp_reg;
      rvalid_next = rvalid_reg & ~s_rready;
      rresp_next = rresp_reg;
      rdata_next = rdata_reg;
      mem_req = 1'b0;
      mem_we = 1'b0;
      mem_addr = 32'h0;
      if (wr_en) begin
         bvalid_next = 1'b1;
         bresp_next = DCMS_RESP_OKAY;
         if (s_awaddr[DCMS_AW-1:4] < 8'(NCH)) begin
            case (s_awaddr[3:2])
               DCMS_OFF_CTL: ctl_next[bch] = merge(ctl_reg[bch], s_wdata, s_wstrb);
               DCMS_OFF_SRC: sa_next[bch] = merge(sa_reg[bch], s_wdata, s_wstrb);
               DCMS_OFF_DST: da_next[bch] = merge(da_reg[bch], s_wdata, s_wstrb);
               default: nxt_next[bch] = merge(nxt_reg[bch], s_wdata, s_wstrb);
            endcase
         end else begin
            case (s_awaddr)
               DCMS_OFF_SWREQ: pend_next = pend_reg | s_wdata[NCH-1:0];
               DCMS_OFF_INTEN: inten_next = s_wdata[NCH-1:0];
               DCMS_OFF_DONE: done_next = done_reg & ~s_wdata[NCH-1:0];
               DCMS_OFF_TBASE: tbase_next = merge(tbase_reg, s_wdata, s_wstrb);
               default: bresp_next = DCMS_RESP_SLVERR;
            endcase
         end
      end
      if (rd_en) begin
         rvalid_next = 1'b1;
         rresp_next = DCMS_RESP_OKAY;
         rdata_next = 32'h0;
         if (s_araddr[DCMS_AW-1:4] < 8'(NCH)) begin
            case (s_araddr[3:2])
               DCMS_OFF_CTL: rdata_next = ctl_reg[rch];
               DCMS_OFF_SRC: rdata_next = sa_reg[rch];
               DCMS_OFF_DST: rdata_next = da_reg[rch];
               default: rdata_next = nxt_reg[rch];
            endcase
         end else begin
            case (s_araddr)
               DCMS_OFF_INTEN: rdata_next = 32'(inten_reg);
               DCMS_OFF_DONE: rdata_next = 32'(done_reg);
               DCMS_OFF_ACTIVE: rdata_next = 32'(run_reg | intab_reg);
               DCMS_OFF_TBASE: rdata_next = tbase_reg;
               DCMS_OFF_SWREQ: rdata_next = 32'h0;
               default: rresp_next = DCMS_RESP_SLVERR;
            endcase
         end
      end
      case (state_reg)
         DCMS_ST_IDLE: begin
            if (gnt_any) begin
               ch_next = gnt;
               widx_next = 2'h0;
               if (ctl_reg[gnt][DCMS_TYPE_BIT]) begin
                  beats_next = 8'h01;
               end else if (ctl_reg[gnt][DCMS_CNT_LSB+:DCMS_CNT_W] < 14'(bsz)) begin
                  beats_next = ctl_reg[gnt][DCMS_CNT_LSB+:8];
               end else begin
                  beats_next = bsz;
               end
               case (gmode)
                  DCMS_MODE_IDLE: begin
                     pend_next[gnt] = 1'b0;
                     run_next[gnt] = 1'b0;
                     intab_next[gnt] = 1'b0;
                     done_next[gnt] = 1'b1;
                  end
                  DCMS_MODE_BASIC, DCMS_MODE_SG: begin
                     if (gmode == DCMS_MODE_SG && !intab_reg[gnt]) begin
                        state_next = DCMS_ST_FETCH;
                     end else if (ctl_reg[gnt][DCMS_CNT_LSB+:DCMS_CNT_W] == '0) begin
                        state_next = DCMS_ST_END;
                     end else begin
                        state_next = DCMS_ST_READ;
                     end
                  end
                  default: begin
                     pend_next[gnt] = 1'b0;
                     run_next[gnt] = 1'b0;
                  end
               endcase
            end
         end
         DCMS_ST_FETCH: begin
            // load entry from base plus link
            mem_req = 1'b1;
            mem_addr = fbase + {28'h0, widx_reg, 2'b00};
            if (mem_ack) begin
               widx_next = widx_reg + 2'h1;
               case (widx_reg)
                  2'h0: ctl_next[ch_reg] = mem_rdata;
                  2'h1: sa_next[ch_reg] = mem_rdata;
                  2'h2: da_next[ch_reg] = mem_rdata;
                  default: begin
                     nxt_next[ch_reg] = mem_rdata;
                     eaddr_next[ch_reg] = fbase;
                     intab_next[ch_reg] = 1'b1;
                     // burst entries start on their own
                     run_next[ch_reg] = ~cctl[DCMS_TYPE_BIT] & (cctl[1:0] != DCMS_MODE_IDLE);
                     state_next = DCMS_ST_IDLE;
                     if (cctl[1:0] == DCMS_MODE_IDLE) begin
                        intab_next[ch_reg] = 1'b0;
                        pend_next[ch_reg] = 1'b0;
                        done_next[ch_reg] = 1'b1;
                     end
                  end
               endcase
            end
         end
         DCMS_ST_READ: begin
            mem_req = 1'b1;
            mem_addr = sa_reg[ch_reg];
            if (mem_ack) begin
               buf_next = mem_rdata;
               state_next = DCMS_ST_WRITE;
            end
         end
         DCMS_ST_WRITE: begin
            mem_req = 1'b1;
            mem_we = 1'b1;
            mem_addr = da_reg[ch_reg];
            if (mem_ack) begin
               sa_next[ch_reg] = sa_reg[ch_reg] + inc_of(cctl[DCMS_SINC_LSB+:2]);
               da_next[ch_reg] = da_reg[ch_reg] + inc_of(cctl[DCMS_DINC_LSB+:2]);
               ctl_next[ch_reg][DCMS_CNT_LSB+:DCMS_CNT_W] = cnt - 14'h1;
               beats_next = beats_reg - 8'h01;
               if (cnt == 14'h1) begin
                  state_next = DCMS_ST_END;
               end else if (beats_reg == 8'h01) begin
                  if (cctl[DCMS_TYPE_BIT]) begin
                     pend_next[ch_reg] = 1'b0;
                  end
                  state_next = DCMS_ST_IDLE;
               end else begin
                  state_next = DCMS_ST_READ;
               end
            end
         end
         DCMS_ST_END: begin
            pend_next[ch_reg] = 1'b0;
            run_next[ch_reg] = 1'b0;
            buf_next = cctl & DCMS_CLR_MASK;
            if (intab_reg[ch_reg]) begin
               if (!cctl[DCMS_TBDIS_BIT]) begin
                  done_next[ch_reg] = 1'b1;
               end
               state_next = DCMS_ST_WBACK;
            end else begin
               ctl_next[ch_reg][DCMS_MODE_LSB+:2] = DCMS_MODE_IDLE;
               done_next[ch_reg] = 1'b1;
               state_next = DCMS_ST_IDLE;
            end
         end
         DCMS_ST_WBACK: begin
            // clear count and mode in table
            mem_req = 1'b1;
            mem_we = 1'b1;
            mem_addr = eaddr_reg[ch_reg];
            if (mem_ack) begin
               widx_next = 2'h0;
               // chain continues only on scatter entry
               if (cctl[1:0] == DCMS_MODE_SG) begin
                  state_next = DCMS_ST_FETCH;
               end else begin
                  intab_next[ch_reg] = 1'b0;
                  ctl_next[ch_reg][DCMS_MODE_LSB+:2] = DCMS_MODE_IDLE;
                  state_next = DCMS_ST_IDLE;
               end
            end
         end
         default: state_next = DCMS_ST_IDLE;
      endcase
      pend_next = pend_next | chan_req;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= DCMS_ST_IDLE;
         ch_reg <= '0;
         widx_reg <= 2'h0;
         beats_reg <= 8'h00;
         buf_reg <= 32'h0;
         tbase_reg <= DCMS_TBASE_RST;
         for (int i = 0; i < NCH; i++) begin
            ctl_reg[i] <= 32'h0;
            sa_reg[i] <= 32'h0;
            da_reg[i] <= 32'h0;
            nxt_reg[i] <= 32'h0;
            eaddr_reg[i] <= 32'h0;
         end
         inten_reg <= '0;
         done_reg <= '0;
         pend_reg <= '0;
         run_reg <= '0;
         intab_reg <= '0;
         bvalid_reg <= 1'b0;
         bresp_reg <= DCMS_RESP_OKAY;
         rvalid_reg <= 1'b0;
         rresp_reg <= DCMS_RESP_OKAY;
         rdata_reg <= 32'h0;
      end else begin
         state_reg <= state_next;
         ch_reg <= ch_next;
         widx_reg <= widx_next;
         beats_reg <= beats_next;
         buf_reg <= buf_next;
         tbase_reg <= tbase_next;
         ctl_reg <= ctl_next;
         sa_reg <= sa_next;
         da_reg <= da_next;
         nxt_reg <= nxt_next;
         eaddr_reg <= eaddr_next;
         inten_reg <= inten_next;
         done_reg <= done_next;
         pend_reg <= pend_next;
         run_reg <= run_next;
         intab_reg <= intab_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         rvalid_reg <= rvalid_next;
         rresp_reg <= rresp_next;
         rdata_reg <= rdata_next;
      end
   end
   assign s_awready = wr_en;
   assign s_wready = wr_en;
   assign s_bvalid = bvalid_reg;
   assign s_bresp = bresp_reg;
   assign s_arready = rd_en;
   assign s_rvalid = rvalid_reg;
   assign s_rresp = rresp_reg;
   assign s_rdata = rdata_reg;
   assign mem_wdata = buf_reg;
   assign mem_size = cctl[DCMS_WIDTH_LSB+:2];
   assign irq = |(done_reg & inten_reg);
   // --------------------------------------------------
   // Checks
   // --------------------------------------------------
   logic cnt_gt1;
   assign cnt_gt1 = cctl[DCMS_CNT_LSB+:DCMS_CNT_W] > 14'h1;
   sequence s_basic_end;
      state_reg == DCMS_ST_END && !intab_reg[ch_reg];
   endsequence
   property p_basic_idle;
      @(posedge clk) disable iff (!rst_n) s_basic_end |=> ctl_reg[$past(ch_reg)][1:0] == DCMS_MODE_IDLE
         && done_reg[$past(ch_reg)] && state_reg == DCMS_ST_IDLE;
   endproperty
   a_basic_idle: assert property (p_basic_idle) else $error("basic end not idle");
   property p_idle_discard;
      @(posedge clk) disable iff (!rst_n) (state_reg == DCMS_ST_IDLE && gnt_any
         && ctl_reg[gnt][1:0] == DCMS_MODE_IDLE) |=> done_reg[$past(gnt)] && state_reg == DCMS_ST_IDLE;
   endproperty
   a_idle_discard: assert property (p_idle_discard) else $error("idle request not discarded");
   property p_fetch_addr;
      @(posedge clk) disable iff (!rst_n) (state_reg == DCMS_ST_FETCH && widx_reg == 2'h0)
         |-> mem_addr == {tbase_reg[31:16], nxt_reg[ch_reg][15:2], 2'b00};
   endproperty
   a_fetch_addr: assert property (p_fetch_addr) else $error("bad fetch address");
   property p_jump_only;
      @(posedge clk) disable iff (!rst_n) (state_reg == DCMS_ST_IDLE && gnt_any && !intab_reg[gnt]
         && ctl_reg[gnt][1:0] == DCMS_MODE_SG) |=> state_reg == DCMS_ST_FETCH [*1] ##0 !mem_we;
   endproperty
   a_jump_only: assert property (p_jump_only) else $error("jump moved data");
   property p_tb_disable;
      @(posedge clk) disable iff (!rst_n) (state_reg == DCMS_ST_END && intab_reg[ch_reg]
         && cctl[DCMS_TBDIS_BIT] && !done_reg[ch_reg] && !s_wvalid) |=> !done_reg[$past(ch_reg)];
   endproperty
   a_tb_disable: assert property (p_tb_disable) else $error("flag set despite disable");
   property p_wback_clear;
      @(posedge clk) disable iff (!rst_n) (state_reg == DCMS_ST_WBACK)
         |-> mem_req && mem_we && mem_wdata[29:16] == 14'h0 && mem_wdata[1:0] == 2'h0;
   endproperty
   a_wback_clear: assert property (p_wback_clear) else $error("entry not cleared");
   property p_single_stop;
      @(posedge clk) disable iff (!rst_n) (item_done && cctl[DCMS_TYPE_BIT] && cnt_gt1)
         |=> state_reg == DCMS_ST_IDLE && !pend_reg[$past(ch_reg)] || $past(chan_req[ch_reg]);
   endproperty
   a_single_stop: assert property (p_single_stop) else $error("single item not stopped");
   sequence s_mid_burst;
      item_done && !cctl[DCMS_TYPE_BIT] && beats_reg > 8'h01 && cnt_gt1;
   endsequence
   property p_burst_go;
      @(posedge clk) disable iff (!rst_n) s_mid_burst |=> state_reg == DCMS_ST_READ && ch_reg == $past(ch_reg);
   endproperty
   a_burst_go: assert property (p_burst_go) else $error("burst preempted");
   property p_prio;
      @(posedge clk) disable iff (!rst_n) (state_reg == DCMS_ST_IDLE && elig[NCH-1]) |=> ch_reg == CHW'(NCH-1);
   endproperty
   a_prio: assert property (p_prio) else $error("top channel not chosen");
   property p_fixed_src;
      @(posedge clk) disable iff (!rst_n) (item_done && cctl[DCMS_SINC_LSB+:2] == DCMS_INC_NONE)
         |=> sa_reg[$past(ch_reg)] == $past(sa_reg[ch_reg]);
   endproperty
   a_fixed_src: assert property (p_fixed_src) else $error("fixed source moved");
endmodule

//--- src/dcms_pkg.sv
// Constants and types shared by the DMA channel mode sequencer.
// Assumes a 32-bit AXI4-Lite register bus and a 32-bit memory port.
package dcms_pkg;
   localparam int DCMS_NCH = 12;
   localparam int DCMS_AW = 12;
   // --------------------------------------------------
   // Descriptor control word layout
   // --------------------------------------------------
   localparam int DCMS_MODE_LSB = 0;
   localparam int DCMS_TYPE_BIT = 2;
   localparam int DCMS_BURST_LSB = 4;
   localparam int DCMS_TBDIS_BIT = 7;
   localparam int DCMS_SINC_LSB = 8;
   localparam int DCMS_DINC_LSB = 10;
   localparam int DCMS_WIDTH_LSB = 12;
   localparam int DCMS_CNT_LSB = 16;
   localparam int DCMS_CNT_W = 14;
   localparam logic [1:0] DCMS_MODE_IDLE = 2'h0;
   localparam logic [1:0] DCMS_MODE_BASIC = 2'h1;
   localparam logic [1:0] DCMS_MODE_SG = 2'h2;
   localparam logic [1:0] DCMS_INC_NONE = 2'h3;
   localparam logic [7:0] DCMS_BURST_MAX = 8'h80;
   localparam logic [31:0] DCMS_CLR_MASK = 32'hC000_FFFC;
   // --------------------------------------------------
   // Register offsets and reset values
   // --------------------------------------------------
   localparam logic [1:0] DCMS_OFF_CTL = 2'h0;
   localparam logic [1:0] DCMS_OFF_SRC = 2'h1;
   localparam logic [1:0] DCMS_OFF_DST = 2'h2;
   localparam logic [1:0] DCMS_OFF_LINK = 2'h3;
   localparam logic [11:0] DCMS_OFF_SWREQ = 12'h400;
   localparam logic [11:0] DCMS_OFF_INTEN = 12'h418;
   localparam logic [11:0] DCMS_OFF_DONE = 12'h424;
   localparam logic [11:0] DCMS_OFF_ACTIVE = 12'h42C;
   localparam logic [11:0] DCMS_OFF_TBASE = 12'h43C;
   localparam logic [31:0] DCMS_TBASE_RST = 32'h2000_0000;
   localparam logic [1:0] DCMS_RESP_OKAY = 2'h0;
   localparam logic [1:0] DCMS_RESP_SLVERR = 2'h2;
   typedef enum logic [5:0] {
      DCMS_ST_IDLE = 6'b000001,
      DCMS_ST_FETCH = 6'b000010,
      DCMS_ST_READ = 6'b000100,
      DCMS_ST_WRITE = 6'b001000,
      DCMS_ST_END = 6'b010000,
      DCMS_ST_WBACK = 6'b100000
   } dcms_state_t;
endpackage

//--- src/dcms_arb.sv
// Fixed-priority channel arbiter, highest index wins.
// Assumes eligibility vector is stable while sampled.
`timescale 1ns/1ps
module dcms_arb #(
   parameter int NCH = 12,
   parameter int CHW = 4
) (
   input wire logic [NCH-1:0] elig,
   output logic [CHW-1:0] gnt,
   output logic any
);
   always_comb begin
      gnt = '0;
      any = 1'b0;
      for (int i = 0; i < NCH; i++) begin
         if (elig[i]) begin
            gnt = CHW'(i);
            any = 1'b1;
         end
      end
   end
endmodule

//--- test/dcms_mem.sv
// Memory slave model on the sequencer's data port.
// Assumes word accesses inside a 4 KB window; slow adds wait cycles.
`timescale 1ns/1ps
module dcms_mem (
   input wire logic clk,
   input wire logic req,
   input wire logic we,
   input wire logic [31:0] addr,
   input wire logic [31:0] wdata,
   input wire logic [1:0] slow,
   output logic [31:0] rdata,
   output logic ack
);
   logic [31:0] m [0:1023];
   logic [1:0] wt = 2'h0;
   logic ack_reg = 1'h0;
   logic [31:0] rdata_reg = 32'h0;
   assign ack = ack_reg;
   assign rdata = rdata_reg;
   // Data bus toggles except when a read is acknowledged
   always @(posedge clk) begin
      ack_reg <= 1'h0;
      rdata_reg <= ~rdata_reg;
      if (req && !ack_reg && wt < slow)
         wt <= wt + 2'h1;
      else if (req && !ack_reg) begin
         wt <= 2'h0;
         ack_reg <= 1'h1;
         if (we)
            m[addr[11:2]] <= wdata;
         else
            rdata_reg <= m[addr[11:2]];
      end
   end
endmodule

//--- test/dcms_top_bench.sv
// Self-checking bench for the DMA channel mode sequencer.
// Assumes an AXI4-Lite master here and the memory model on the data port.
`timescale 1ns/1ps
module dcms_top_bench;
   import dcms_pkg::*;
   typedef struct {logic [2:0] b; logic [1:0] inc; logic [13:0] n;} dcms_row_t;
   dcms_row_t rows [4] = '{'{3'h7, 2'h2, 14'h3}, '{3'h6, 2'h2, 14'h4}, '{3'h0, 2'h2, 14'h5}, '{3'h7, 2'h3, 14'h2}};
   logic clk = 0, nrst = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, mreq, mwe, ack, awr, wrd, bv, arr, rv, irq;
   logic [11:0] awa = 0, ara = 0, req = 0;
   logic [31:0] wd = 0, rdat, maddr, mwd, mrd, got, resp, ca, ev;
   logic [1:0] br, rr, msz, slow = 0;
   int miscompares = 0, comparisons = 0, cyc = 0, nacc = 0, n0;
   dcms_top dut_u (.clk(clk), .nrst(nrst), .s_awaddr(awa), .s_awvalid(awv), .s_awready(awr), .s_wdata(wd),
      .s_wstrb(4'hF), .s_wvalid(wv), .s_wready(wrd), .s_bresp(br), .s_bvalid(bv), .s_bready(bry), .s_araddr(ara),
      .s_arvalid(arv), .s_arready(arr), .s_rdata(rdat), .s_rresp(rr), .s_rvalid(rv), .s_rready(rry),
      .chan_req(req), .mem_req(mreq), .mem_we(mwe), .mem_addr(maddr), .mem_wdata(mwd), .mem_size(msz),
      .mem_rdata(mrd), .mem_ack(ack), .irq(irq));
   dcms_mem mem_u (.clk(clk), .req(mreq), .we(mwe), .addr(maddr), .wdata(mwd), .slow(slow), .rdata(mrd), .ack(ack));
   always #20 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (mreq && ack)
         nacc <= nacc + 1;
      if (cyc == 30000) begin
         miscompares++;
         conclude();
      end
   end
   task automatic conclude;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         miscompares++;
         $display("unexpected at %0t: saw %h want %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      awa <= a;
      wd <= d;
      awv <= 1;
      wv <= 1;
      do @(posedge clk); while (!awr);
      awv <= 0;
      wv <= 0;
      bry <= 1;
      do @(posedge clk); while (!bv);
      resp = {30'h0, br};
      bry <= 0;
   endtask
   task automatic rd(input logic [11:0] a);
      ara <= a;
      arv <= 1;
      do @(posedge clk); while (!arr);
      arv <= 0;
      rry <= 1;
      do @(posedge clk); while (!rv);
      got = rdat;
      resp = {30'h0, rr};
      rry <= 0;
   endtask
   task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v);
      rd(a);
      for (int i = 0; i < 80 && (got & m) !== v; i++)
         rd(a);
   endtask
   function automatic logic [31:0] cw(input logic [1:0] m, t, logic [2:0] b, logic [1:0] inc, logic [13:0] n);
      return {2'h0, n, 4'h0, inc, inc, 1'h0, b, 1'h0, t[0], m};
   endfunction
   initial begin
      for (int k = 0; k < 16; k++)
         mem_u.m[16+k] = 32'hA500 + k;
      repeat (20) @(posedge clk);
      nrst <= 1;
      repeat (3) @(posedge clk);
      rd(DCMS_OFF_TBASE);
      chk(got, 32'h2000_0000);
      rd(12'h0);
      chk(got, 32'h0);
      rd(12'hFFC);
      chk(resp, 32'(DCMS_RESP_SLVERR));
      chk(got, 32'h0);
      wr(DCMS_OFF_INTEN, 32'hFFF);
      for (int r = 0; r < 4; r++) begin
         slow <= r[1:0];
         for (int k = 0; k < 8; k++)
            mem_u.m[64+k] = 32'h0;
         wr(12'(16*r+4), 32'h40);
         wr(12'(16*r+8), 32'h100);
         wr(12'(16*r), cw(DCMS_MODE_BASIC, 2'h0, rows[r].b, rows[r].inc, rows[r].n));
         wr(DCMS_OFF_SWREQ, 32'(1 << r));
         poll(DCMS_OFF_DONE, 32'(1 << r), 32'(1 << r));
         chk({31'h0, irq}, 32'h1);
         rd(12'(16*r));
         chk(got & 32'h3FFF_0003, 32'h0);
         for (int k = 0; k < 8; k++) begin
            ev = k >= rows[r].n ? 32'h0 : rows[r].inc == DCMS_INC_NONE ? (k == 0 ? 32'hA500 : 32'h0) : 32'hA500 + k;
            chk(mem_u.m[64+k], ev);
         end
         wr(DCMS_OFF_DONE, 32'hFFF);
         chk({31'h0, irq}, 32'h0);
      end
      n0 = nacc;
      wr(12'h50, 32'h0);
      wr(DCMS_OFF_SWREQ, 32'h20);
      poll(DCMS_OFF_DONE, 32'h20, 32'h20);
      chk(got & 32'h20, 32'h20);
      chk(32'(nacc - n0), 32'h0);
      n0 = nacc;
      wr(12'h70, cw(2'h3, 2'h0, 3'h7, 2'h2, 14'h1));
      wr(DCMS_OFF_SWREQ, 32'h80);
      repeat (20) @(posedge clk);
      rd(DCMS_OFF_DONE);
      chk(got & 32'h80, 32'h0);
      chk(32'(nacc - n0), 32'h0);
      wr(12'h64, 32'h40);
      wr(12'h68, 32'h100);
      wr(12'h60, cw(DCMS_MODE_BASIC, 2'h1, 3'h0, 2'h2, 14'h2));
      req <= 12'h040;
      @(posedge clk);
      req <= 12'h0;
      poll(12'h60, 32'h3FFF_0000, 32'h0001_0000);
      chk(got & 32'h3FFF_0000, 32'h0001_0000);
      chk(got[1:0], DCMS_MODE_BASIC);
      req <= 12'h040;
      @(posedge clk);
      req <= 12'h0;
      poll(12'h60, 32'h3, 32'h0);
      chk(got[1:0], DCMS_MODE_IDLE);
      chk(got[29:16], 32'h0);
      wr(12'hB4, 32'h48);
      wr(12'h84, 32'h40);
      wr(12'hB0, cw(DCMS_MODE_BASIC, 2'h1, 3'h0, 2'h2, 14'h1) | 32'h2000);
      wr(12'h80, cw(DCMS_MODE_BASIC, 2'h1, 3'h0, 2'h2, 14'h1));
      req <= 12'h900;
      @(posedge clk);
      req <= 12'h0;
      while (!mreq) @(posedge clk);
      chk(maddr, 32'h48);
      chk({30'h0, msz}, 32'h2);
      poll(DCMS_OFF_DONE, 32'h900, 32'h900);
      chk(got & 32'h900, 32'h900);
      ca = cw(DCMS_MODE_SG, 2'h0, 3'h7, 2'h2, 14'h1) | 32'h80;
      mem_u.m[192] = ca;
      mem_u.m[193] = 32'h40;
      mem_u.m[194] = 32'h200;
      mem_u.m[195] = 32'h340;
      mem_u.m[208] = cw(DCMS_MODE_BASIC, 2'h0, 3'h7, 2'h2, 14'h1);
      mem_u.m[209] = 32'h44;
      mem_u.m[210] = 32'h204;
      mem_u.m[211] = 32'h0;
      wr(12'hAC, 32'hFFFF_0303);
      wr(12'hA0, cw(DCMS_MODE_SG, 2'h0, 3'h0, 2'h2, 14'h0));
      wr(DCMS_OFF_SWREQ, 32'h400);
      poll(12'hA0, 32'h3, 32'h0);
      repeat (20) @(posedge clk);
      chk(mem_u.m[192], ca & 32'hC000_FFFC);
      chk(mem_u.m[128], 32'hA500);
      chk(mem_u.m[129], 32'hA501);
      chk(mem_u.m[208] & 32'h3FFF_0003, 32'h0);
      rd(DCMS_OFF_DONE);
      chk(got & 32'h400, 32'h400);
      conclude();
   end
endmodule
